// *** inc/rtc_trim_consts.svh ***
`ifndef RTC_TRIM_CONSTS_SVH
`define RTC_TRIM_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define TRIM_CTRL_IDX 8'h08
`define LOAD_CAP_IDX 8'h12
`define TEST_CTRL_IDX 8'h0a
`define TRIM_STAT_IDX 8'h0b

// Field positions.
`define MAG_LSB 0
`define MAG_MSB 4
`define DIR_BIT 5
`define CTRL_USED_MSB 5
`define TEST_EN_BIT 0
`define STAT_CORR_BIT 16

// Reset values.
`define TRIM_CTRL_RST 6'h00
`define LOAD_CAP_RST 8'h00
`define TEST_EN_RST 1'b0

// Rates and timing.
`define CLK_HZ 25000000
`define OSC_HZ 32768
`define TAP_HZ 512
`define FT_DIV (`OSC_HZ / `TAP_HZ)
`define FT_CNT_W 6
`define HUN_PER_SEC 100
`define NOMINAL_IN 512
`define POS_IN 511
`define NEG_IN 513
`define POS_CYCLE_MIN 8
`define NEG_CYCLE_MIN 16
`define SEC_PER_MIN 60
`define POS_CYCLE_SEC (`POS_CYCLE_MIN * `SEC_PER_MIN)
`define NEG_CYCLE_SEC (`NEG_CYCLE_MIN * `SEC_PER_MIN)

`endif

// *** inc/rtc_trim_pkg.sv ***
package rtc_trim_pkg;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_TRIM = 3'b001,
    SEL_CAP  = 3'b010,
    SEL_TEST = 3'b011,
    SEL_STAT = 3'b100
  } reg_sel_e;

  typedef logic [9:0] sec_count_t;

endpackage

// *** inc/rate_if.sv ***
`timescale 1ns/1ps
interface rate_if #(
  parameter int W = 10
);
  logic step_en;
  logic [W-1:0] inc;
  logic [W-1:0] modulus;
  logic pulse;

  modport div (
    input step_en,
    input inc,
    input modulus,
    output pulse
  );

  modport src (
    output step_en,
    output inc,
    output modulus,
    input pulse
  );
endinterface

// *** rtl/rate_divider.sv ***
`timescale 1ns/1ps
// Emits exactly inc pulses for every modulus steps, spread evenly.
module rate_divider #(
  parameter int W = 10
) (
  input wire logic hclk,
  input wire logic hresetn,
  rate_if.div port
);

  logic [W-1:0] acc_q;
  logic [W:0] sum;

  assign sum = {1'b0, acc_q} + {1'b0, port.inc};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      acc_q <= '0;
      port.pulse <= 1'b0;
    end
    else if (port.step_en)
    begin
      if (sum >= {1'b0, port.modulus})
      begin
        acc_q <= W'(sum - {1'b0, port.modulus});
        port.pulse <= 1'b1;
      end
      else
      begin
        acc_q <= sum[W-1:0];
        port.pulse <= 1'b0;
      end
    end
    else
    begin
      port.pulse <= 1'b0;
    end
  end

endmodule

// *** rtl/rtc_periodic_counter_correction.sv ***
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "rtc_trim_consts.svh"

// Summary of operation
// - Prescaler chain runs from nominal 32768 Hz oscillator.
// - Uncorrected: 100 output pulses per 512 inputs.
// - Positive corrected second: 100 per 511.
// - Negative corrected second: 100 per 513.
// - Zero magnitude never corrects, either sign.
// - Positive: first N seconds of 8 minutes.
// - Negative: N seconds of each 16 minutes.
// - Magnitude is bits 4..0 of trim control.
// - Bit 5 picks direction, 1 speeds up.
// - Step worth about +4.068 or -2.034 ppm.
// - Enabled test output is 512 Hz square.
// - Correction sits after tap, invisible on test output.
module rtc_periodic_counter_correction #(
  parameter int CLK_HZ = `CLK_HZ,
  parameter int OSC_HZ = `OSC_HZ
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic freq_test_output,
  output logic hundredth_tick,
  output logic second_tick,
  output logic [7:0] input_side_load_cap,
  output logic [7:0] output_side_load_cap
);

  localparam int OSC_W = $clog2(CLK_HZ) + 1;
  localparam int HUN_W = 10;

  logic [`CTRL_USED_MSB:0] trim_ctrl_q;
  logic [7:0] load_cap_q;
  logic test_en_q;
  rtc_trim_pkg::reg_sel_e sel_q;
  rtc_trim_pkg::reg_sel_e sel_d;
  logic wr_q;
  logic [`FT_CNT_W-1:0] ft_cnt_q;
  logic [6:0] hun_cnt_q;
  rtc_trim_pkg::sec_count_t sec_q;
  logic [4:0] trim_magnitude;
  logic trim_direction;
  logic corrected;
  logic tap_pulse;
  logic sec_end;
  logic [9:0] cycle_last;
  logic [HUN_W-1:0] in_per_100;
  logic bus_take;
  logic [31:0] rd_mux;

  rate_if #(.W(OSC_W)) osc ();
  rate_if #(.W(HUN_W)) hun ();

  assign trim_magnitude = trim_ctrl_q[`MAG_MSB:`MAG_LSB];
  assign trim_direction = trim_ctrl_q[`DIR_BIT];

  // oscillator rate
  // The 25 MHz clock is not a multiple of 32768 Hz, so a fractional
  // accumulator keeps the long-term rate exact at the cost of jitter.
  assign osc.step_en = 1'b1;
  assign osc.inc = OSC_W'(OSC_HZ);
  assign osc.modulus = OSC_W'(CLK_HZ);

  rate_divider #(.W(OSC_W)) osc_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .port(osc)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ft_cnt_q <= '0;
    else if (osc.pulse)
      ft_cnt_q <= ft_cnt_q + 1'b1;
  end

  // The tap marks the end of each 64-pulse group of the oscillator.
  assign tap_pulse = osc.pulse && (ft_cnt_q == `FT_CNT_W'(`FT_DIV - 1));

  // Gating the counter's top bit with the enable keeps the pin low while unused.
  // test square wave
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      freq_test_output <= 1'b0;
    else
      freq_test_output <= test_en_q & ft_cnt_q[`FT_CNT_W-1];
  end

  // Comparing the count with N keeps the corrected seconds at the
  // start of each cycle.
  // corrected second flag
  assign corrected = (trim_magnitude != 5'h00) &&
                     (sec_q < {5'h00, trim_magnitude});

  // The ratio follows the flag at once, so a trim write mid-second
  // shifts the remaining pulses of the second in progress.
  // nominal or corrected ratio
  always_comb
  begin
    if (!corrected)
      in_per_100 = HUN_W'(`NOMINAL_IN);
    else if (trim_direction)
      in_per_100 = HUN_W'(`POS_IN);
    else
      in_per_100 = HUN_W'(`NEG_IN);
  end

  assign hun.step_en = tap_pulse;
  assign hun.inc = HUN_W'(`HUN_PER_SEC);
  assign hun.modulus = in_per_100;

  rate_divider #(.W(HUN_W)) hun_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .port(hun)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hun_cnt_q <= '0;
    else if (hun.pulse)
      hun_cnt_q <= sec_end ? 7'h00 : hun_cnt_q + 1'b1;
  end

  assign sec_end = hun.pulse &&
                   (hun_cnt_q == 7'(`HUN_PER_SEC - 1));

  assign cycle_last = trim_direction ? 10'(`POS_CYCLE_SEC - 1) :
                                       10'(`NEG_CYCLE_SEC - 1);

  // free-running seconds count
  // A direction change may leave the count past the shorter cycle,
  // so the wrap compares with greater-or-equal.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sec_q <= '0;
    else if (sec_end)
      sec_q <= (sec_q >= cycle_last) ? 10'h000 : sec_q + 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hundredth_tick <= 1'b0;
    else
      hundredth_tick <= hun.pulse;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      second_tick <= 1'b0;
    else
      second_tick <= sec_end;
  end

  // Bus address decode.
  always_comb
  begin
    sel_d = rtc_trim_pkg::SEL_NONE;
    if (haddr[31:10] == 22'h000000 && haddr[1:0] == 2'b00)
    begin
      if (haddr[9:2] == `TRIM_CTRL_IDX)
        sel_d = rtc_trim_pkg::SEL_TRIM;
      else if (haddr[9:2] == `LOAD_CAP_IDX)
        sel_d = rtc_trim_pkg::SEL_CAP;
      else if (haddr[9:2] == `TEST_CTRL_IDX)
        sel_d = rtc_trim_pkg::SEL_TEST;
      else if (haddr[9:2] == `TRIM_STAT_IDX)
        sel_d = rtc_trim_pkg::SEL_STAT;
    end
  end

  // Bus address phase accepted.
  assign bus_take = hready && hsel && htrans[1];

  // Read data is captured in the address phase so hrdata is a flop
  // and the slave never needs a wait state.
  always_comb
  begin
    rd_mux = 32'h00000000;
    unique case (sel_d)
      rtc_trim_pkg::SEL_NONE:
        rd_mux = 32'h00000000;
      rtc_trim_pkg::SEL_TRIM:
        rd_mux = {26'h0000000, trim_ctrl_q};
      rtc_trim_pkg::SEL_CAP:
        rd_mux = {24'h000000, load_cap_q};
      rtc_trim_pkg::SEL_TEST:
        rd_mux = {31'h00000000, test_en_q};
      rtc_trim_pkg::SEL_STAT:
        rd_mux = {15'h0000, corrected, 6'h00, sec_q};
      default:
        rd_mux = 32'h00000000;
    endcase
  end

  // Idle cycles and writes read as zero, so stale data never lingers
  // on the bus after its data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (hready)
      hrdata <= (bus_take && !hwrite) ? rd_mux : 32'h00000000;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sel_q <= rtc_trim_pkg::SEL_NONE;
      wr_q <= 1'b0;
    end
    else if (hready)
    begin
      sel_q <= bus_take ? sel_d : rtc_trim_pkg::SEL_NONE;
      wr_q <= bus_take && hwrite;
    end
  end

  // Zero wait states: every transfer ends after one data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hreadyout <= 1'b1;
    else
      hreadyout <= 1'b1;
  end

  // Unmapped addresses still answer okay, so no error path exists.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  // Only the used low bits are stored; reserved bits read zero.
  // trim control register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      trim_ctrl_q <= `TRIM_CTRL_RST;
    else if (wr_q && sel_q == rtc_trim_pkg::SEL_TRIM)
      trim_ctrl_q <= hwdata[`CTRL_USED_MSB:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      load_cap_q <= `LOAD_CAP_RST;
    else if (wr_q && sel_q == rtc_trim_pkg::SEL_CAP)
      load_cap_q <= hwdata[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      test_en_q <= `TEST_EN_RST;
    else if (wr_q && sel_q == rtc_trim_pkg::SEL_TEST)
      test_en_q <= hwdata[`TEST_EN_BIT];
  end

  // The raw trim value drives both sides; the capacitor bank decodes
  // it, so software reads back exactly the low byte it wrote.
  // both capacitor outputs
  assign input_side_load_cap = load_cap_q;
  assign output_side_load_cap = load_cap_q;

endmodule

// *** sim/rtc_trim_asserts.sv ***
`timescale 1ns/1ps
module rtc_trim_asserts #(
  parameter int CLK_HZ = 1,
  parameter int OSC_HZ = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic freq_test_output,
  input wire logic hundredth_tick,
  input wire logic second_tick,
  input wire logic [7:0] input_side_load_cap,
  input wire logic [7:0] output_side_load_cap
);
  localparam int TAP = 64 * CLK_HZ / OSC_HZ;
  localparam int HALF = TAP / 2;
  logic [31:0] run_q, gap_q;
  logic [6:0] hun_q;
  logic tk, fell_q, seen_q, cap_q, trim_q, rd_q;
  assign tk = hsel && hready && htrans[1];
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // The first edge after enable may fall mid-phase, so wait for a full fall.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {run_q, gap_q, hun_q} <= '0;
      {fell_q, seen_q, cap_q, trim_q, rd_q} <= '0;
    end
    else
    begin
      run_q <= $changed(freq_test_output) ? 32'h1 : run_q + 32'h1;
      fell_q <= fell_q | $fell(freq_test_output);
      gap_q <= hundredth_tick ? 32'h1 : gap_q + 32'h1;
      seen_q <= seen_q | hundredth_tick;
      hun_q <= second_tick ? 7'h0 : hun_q + 7'(hundredth_tick);
      cap_q <= tk && hwrite && haddr == 32'h48;
      trim_q <= tk && !hwrite && haddr == 32'h20;
      rd_q <= tk && !hwrite;
    end
  end
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  idle_rdata_a: assert property (!rd_q |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  trim_rsvd_a: assert property (
    trim_q |-> hrdata[31:6] == 26'h0) else $error("trim reserved bits set");
  cap_pair_a: assert property (
    input_side_load_cap == output_side_load_cap)
    else $error("load cap outputs differ");
  cap_write_a: assert property (
    cap_q |=> {24'h0, input_side_load_cap} == ($past(hwdata) & 32'hff))
    else $error("load cap write not applied");
  test_half_a: assert property (
    $changed(freq_test_output) && fell_q |-> run_q == HALF)
    else $error("test output half period wrong");
  hun_gap_a: assert property (
    hundredth_tick && seen_q |-> gap_q == 5 * TAP || gap_q == 6 * TAP)
    else $error("hundredth tick spacing wrong");
  sec_count_a: assert property (
    second_tick |-> hundredth_tick && hun_q == 7'd99)
    else $error("second tick not on hundredth tick");
  cover property (second_tick);
  cover property (cap_q);
  cover property ($rose(freq_test_output));
endmodule
bind rtc_periodic_counter_correction rtc_trim_asserts #(
  .CLK_HZ(CLK_HZ), .OSC_HZ(OSC_HZ)) chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hresp(hresp),
  .hreadyout(hreadyout), .freq_test_output(freq_test_output),
  .hundredth_tick(hundredth_tick), .second_tick(second_tick),
  .input_side_load_cap(input_side_load_cap),
  .output_side_load_cap(output_side_load_cap));

// *** sim/rtc_periodic_counter_correction_tb.sv ***
`timescale 1ns/1ps
module rtc_periodic_counter_correction_tb;
  localparam int TAP = 64;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic rd_ph = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic hreadyout, hresp, freq_test_output, hundredth_tick, second_tick;
  logic [7:0] cap_v;
  logic [31:0] rd_q[$], per_q[$];
  int err_count = 0, total_checks = 0, cyc = 0, last = 0;
  rtc_periodic_counter_correction #(.CLK_HZ(1), .OSC_HZ(1)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .freq_test_output(freq_test_output),
    .hundredth_tick(hundredth_tick), .second_tick(second_tick),
    .input_side_load_cap(), .output_side_load_cap());
  initial forever #20 hclk = ~hclk;
  task wrap_up;
    if (rd_q.size() != 0 || per_q.size() != 0)
      err_count++;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task check(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task xfer(input logic [31:0] a, w, d, e);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w[0];
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_ph <= !w[0];
    if (!w[0])
      rd_q.push_back(e);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask
  task wait_tick;
    @(posedge hclk);
    for (int i = 0; i < 40000 && second_tick !== 1'b1; i++)
      @(posedge hclk);
    if (second_tick !== 1'b1)
    begin
      err_count++;
      $display("ERROR %0t: second tick missing", $time);
    end
  endtask
  always @(posedge hclk)
  begin
    cyc++;
    if (rd_ph && hreadyout === 1'b1)
      check(hrdata, rd_q.pop_front());
    if (second_tick === 1'b1)
    begin
      if (per_q.size() > 0)
        check(32'(cyc - last), per_q.pop_front());
      last = cyc;
    end
    if (cyc == 100000)
    begin
      err_count++;
      wrap_up();
    end
  end
  initial
  begin
    void'($urandom(33103));
    cap_v = 8'($urandom);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(32'h20, 0, 0, 32'h0);
    xfer(32'h48, 0, 0, 32'h0);
    xfer(32'h48, 1, {24'($urandom), cap_v}, 0);
    xfer(32'h48, 0, 0, {24'h0, cap_v});
    xfer(32'h20, 1, ($urandom & 32'hffffffc0) | 32'h22, 0);
    xfer(32'h20, 0, 0, 32'h22);
    xfer(32'h28, 1, 32'h1, 0);
    xfer(32'h28, 0, 0, 32'h1);
    xfer(32'h3c, 1, $urandom, 0);
    xfer(32'h3c, 0, 0, 0);
    xfer(32'h2c, 0, 0, 32'h10000);
    $display("test regs done");
    wait_tick;
    @(posedge hclk);
    per_q.push_back(511 * TAP);
    wait_tick;
    // Writes finish before the next tap, while the accumulator sits at zero.
    xfer(32'h20, 1, 32'h1f, 0);
    xfer(32'h2c, 0, 0, 32'h10002);
    xfer(32'h20, 1, 32'h22, 0);
    xfer(32'h2c, 0, 0, 32'h2);
    for (int i = 0; i < 2; i++)
    begin
      xfer(32'h20, 1, 32'(i) << 5, 0);
      xfer(32'h2c, 0, 0, 32'h2);
    end
    // trim held through each measured second
    xfer(32'h20, 1, 32'h1f, 0);
    per_q.push_back(513 * TAP);
    wait_tick;
    @(posedge hclk);
    $display("test trim done");
    wrap_up();
  end
endmodule
